// ==== hdl/timer_b_pkg.sv ====
// Package with constants and carrier types for the prescaled timer b
package timer_b_pkg;

  // ----------------------------------------------------------------
  // Operating modes and count sources
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_WAVE = 2'h1;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  localparam logic [1:0] MODE_WAIT_ONESHOT = 2'h3;

  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_COMPANION = 2'h2;
  localparam logic [1:0] SRC_F2 = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and divider widths
  // ----------------------------------------------------------------
  localparam logic [7:0] RELOAD_RESET = 8'hFF;
  localparam int DIV8_WIDTH = 3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] op_mode;
    logic [1:0] source_sel;
    logic source_cut_bit;
    logic write_target_sel;
  } mode_cfg_t;

  typedef struct packed {
    logic wr_prescaler;
    logic wr_secondary;
    logic wr_primary;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic [7:0] prescaler_reg;
    logic [7:0] primary_reload_reg;
    logic [7:0] secondary_reload_reg;
  } reg_read_t;

endpackage

// ==== hdl/count_source_gen.sv ====
// Count source selector producing one-cycle enables of the system clock
`timescale 1ns/1ns
`default_nettype none
module count_source_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Selection
  input wire logic [1:0] source_sel,
  input wire logic source_cut_bit,
  // Companion timer underflow, same clock domain
  input wire logic companion_underflow,
  // Count source tick
  output logic source_tick
);

  // ----------------------------------------------------------------
  // Free running divider for f2 and f8
  // ----------------------------------------------------------------
  logic [timer_b_pkg::DIV8_WIDTH-1:0] div;
  logic [timer_b_pkg::DIV8_WIDTH-1:0] next_div;
  logic next_tick;

  always_comb begin
    next_div = div + 3'h1;
    next_tick = 1'b0;
    if (!source_cut_bit) begin
      unique case (source_sel)
        timer_b_pkg::SRC_F1: next_tick = 1'b1;
        timer_b_pkg::SRC_F2: next_tick = div[0];
        timer_b_pkg::SRC_F8: next_tick = &div;
        timer_b_pkg::SRC_COMPANION: next_tick = companion_underflow;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      div <= '0;
      source_tick <= 1'b0;
    end else begin
      div <= next_div;
      source_tick <= next_tick;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/prescaled_timer_b.sv ====
// Eight bit prescaler and eight bit down counter with primary and secondary reload
// ----------------------------------------------------------------
// Summary of operation
// - Forced stop returns prescaler, reloads, start, status and one-shot status to reset.
// - Status flag shows counting in timer/waveform modes, trigger accepted in one-shot modes.
// - One-shot control takes effect only in one-shot modes.
// - Forced stop loads FFh into prescaler, secondary and primary registers.
// - With both reloads in use, primary and secondary alternate on successive underflows.
// - Primary register read returns live timer count, even in secondary period.
// - Count source is f1, f2, f8 or companion timer underflow.
// - Timer mode counts down and reloads primary on underflow.
// - Division equals (prescaler+1) times (primary+1).
// - Writing start bit 1 begins counting.
// - Writing start bit 0 or forced stop 1 stops counting.
// - Each timer underflow in timer mode raises an interrupt request unless a pending reload-to-counter transfer replaces it.
// - Count readable through primary and prescaler registers.
// - Writes while stopped update reload and counter.
// - While counting in timer mode, target select 0 writes both, 1 writes reload only; other modes write reload only.
// - Reload-to-counter transfers synchronise to source and prescaler underflow.
// - Timer mode ignores one-shot control and secondary register.
// - Eight bit timer stage fed by eight bit prescaler, each reload plus counter.
// - Mode field selects timer, waveform, one-shot and wait one-shot.
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module prescaled_timer_b (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Control register writes
  input wire logic ctrl_write,
  input wire logic count_start_bit,
  input wire logic forced_stop_bit,
  // Mode register
  input wire timer_b_pkg::mode_cfg_t mode_cfg,
  // One-shot control: trigger request
  input wire logic oneshot_trigger,
  // Data register writes
  input wire timer_b_pkg::reg_write_t reg_write,
  // Companion timer underflow
  input wire logic companion_underflow,
  // Status and readback
  output timer_b_pkg::reg_read_t reg_read,
  output logic start_state,
  output logic count_status_flag,
  output logic oneshot_status_flag,
  output logic underflow_irq
);

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  logic source_tick;

  count_source_gen u_source (
    .clock(clock),
    .srst(srst),
    .source_sel(mode_cfg.source_sel),
    .source_cut_bit(mode_cfg.source_cut_bit),
    .companion_underflow(companion_underflow),
    .source_tick(source_tick)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] pre_reload, pre_count, pri_reload, sec_reload, tmr_count;
  logic [7:0] next_pre_reload, next_pre_count, next_pri_reload, next_sec_reload;
  logic [7:0] next_tmr_count;
  logic pre_pending, tmr_pending, next_pre_pending, next_tmr_pending;
  logic start, running, in_secondary, oneshot_flag, irq;
  logic next_start, next_running, next_in_secondary, next_oneshot_flag, next_irq;
  logic is_timer, is_oneshot, alternate, write_both, pre_under, tmr_under;

  always_comb begin
    is_timer = (mode_cfg.op_mode == timer_b_pkg::MODE_TIMER);
    is_oneshot = mode_cfg.op_mode[1];
    alternate = !is_timer;
    // Outside timer mode target select is assumed 1 by software
    write_both = !running || (is_timer && !mode_cfg.write_target_sel);
    pre_under = running && source_tick && (pre_count == 8'h00);
    tmr_under = pre_under && (tmr_count == 8'h00);

    next_pre_reload = pre_reload;
    next_pre_count = pre_count;
    next_pri_reload = pri_reload;
    next_sec_reload = sec_reload;
    next_tmr_count = tmr_count;
    next_pre_pending = pre_pending;
    next_tmr_pending = tmr_pending;
    next_start = start;
    next_running = running;
    next_in_secondary = in_secondary;
    next_oneshot_flag = oneshot_flag;
    next_irq = 1'b0;

    // Prescaler stage: reload-synchronised transfer on the count source
    if (running && source_tick) begin
      if (pre_pending) begin
        next_pre_count = pre_reload;
        next_pre_pending = 1'b0;
      end else if (pre_under) begin
        next_pre_count = pre_reload;
      end else begin
        next_pre_count = pre_count - 8'h01;
      end
    end

    // Timer stage steps on prescaler underflow
    if (pre_under) begin
      if (tmr_pending) begin
        next_tmr_count = pri_reload;
        next_tmr_pending = 1'b0;
        next_in_secondary = 1'b0;
      end else if (tmr_under) begin
        next_irq = is_timer || in_secondary;
        if (alternate && !in_secondary) begin
          next_tmr_count = sec_reload;
          next_in_secondary = 1'b1;
        end else begin
          next_tmr_count = pri_reload;
          next_in_secondary = 1'b0;
        end
      end else begin
        next_tmr_count = tmr_count - 8'h01;
      end
    end

    // Register writes
    if (reg_write.wr_prescaler) begin
      next_pre_reload = reg_write.data;
      if (!running) begin
        next_pre_count = reg_write.data;
      end else if (write_both) begin
        next_pre_pending = 1'b1;
      end
    end
    if (reg_write.wr_secondary && !is_timer) begin
      next_sec_reload = reg_write.data;
    end
    if (reg_write.wr_primary) begin
      next_pri_reload = reg_write.data;
      if (!running) begin
        next_tmr_count = reg_write.data;
        next_in_secondary = 1'b0;
      end else if (write_both) begin
        next_tmr_pending = 1'b1;
      end
    end

    // Start and stop
    if (ctrl_write) begin
      next_start = count_start_bit;
    end
    if (is_oneshot && oneshot_trigger && start) begin
      next_oneshot_flag = 1'b1;
    end
    // Status follows a start at the next count source edge, a stop on the next clock
    if (source_tick || !start) begin
      next_running = start && (!is_oneshot || oneshot_flag);
    end
    // Clearing on the start bit alone leaves no secondary phase behind by the time
    // software may change the mode, so timer mode never inherits it
    if (!start) begin
      next_in_secondary = 1'b0;
    end

    // Forced stop wins over all but the interrupt pulse
    if (ctrl_write && forced_stop_bit) begin
      next_pre_reload = timer_b_pkg::RELOAD_RESET;
      next_pre_count = timer_b_pkg::RELOAD_RESET;
      next_pri_reload = timer_b_pkg::RELOAD_RESET;
      next_sec_reload = timer_b_pkg::RELOAD_RESET;
      next_tmr_count = timer_b_pkg::RELOAD_RESET;
      next_pre_pending = 1'b0;
      next_tmr_pending = 1'b0;
      next_start = 1'b0;
      next_running = 1'b0;
      next_in_secondary = 1'b0;
      next_oneshot_flag = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pre_reload <= timer_b_pkg::RELOAD_RESET;
      pre_count <= timer_b_pkg::RELOAD_RESET;
      pri_reload <= timer_b_pkg::RELOAD_RESET;
      sec_reload <= timer_b_pkg::RELOAD_RESET;
      tmr_count <= timer_b_pkg::RELOAD_RESET;
      pre_pending <= 1'b0;
      tmr_pending <= 1'b0;
      start <= 1'b0;
      running <= 1'b0;
      in_secondary <= 1'b0;
      oneshot_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      pre_reload <= next_pre_reload;
      pre_count <= next_pre_count;
      pri_reload <= next_pri_reload;
      sec_reload <= next_sec_reload;
      tmr_count <= next_tmr_count;
      pre_pending <= next_pre_pending;
      tmr_pending <= next_tmr_pending;
      start <= next_start;
      running <= next_running;
      in_secondary <= next_in_secondary;
      oneshot_flag <= next_oneshot_flag;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_read <= '{default: timer_b_pkg::RELOAD_RESET};
      start_state <= 1'b0;
      count_status_flag <= 1'b0;
      oneshot_status_flag <= 1'b0;
      underflow_irq <= 1'b0;
    end else begin
      reg_read.prescaler_reg <= next_pre_count;
      reg_read.primary_reload_reg <= next_tmr_count;
      reg_read.secondary_reload_reg <= next_sec_reload;
      start_state <= next_start;
      count_status_flag <= next_running;
      oneshot_status_flag <= next_oneshot_flag;
      underflow_irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stop_clears_a: assert property (@(posedge clock) disable iff (srst)
    ctrl_write && forced_stop_bit |=> !start_state && !count_status_flag && !oneshot_status_flag)
    else $error("forced stop did not clear status");
  stop_loads_a: assert property (@(posedge clock) disable iff (srst)
    ctrl_write && forced_stop_bit |=> reg_read.prescaler_reg == 8'hFF &&
      reg_read.primary_reload_reg == 8'hFF && reg_read.secondary_reload_reg == 8'hFF)
    else $error("forced stop did not load FFh");
  start_sets_a: assert property (@(posedge clock) disable iff (srst)
    ctrl_write && count_start_bit && !forced_stop_bit |=> start_state)
    else $error("start bit not taken");
  stop_halts_a: assert property (@(posedge clock) disable iff (srst)
    ctrl_write && !count_start_bit |=> !start_state ##1 !count_status_flag)
    else $error("stop did not halt count");
  // At most one pulse per underflow; with both stages at zero on f1 in timer mode the pulses run back to back
  irq_pulse_a: assert property (@(posedge clock) disable iff (srst)
    !tmr_under |=> !underflow_irq)
    else $error("interrupt without underflow");
  timer_irq_a: assert property (@(posedge clock) disable iff (srst)
    is_timer && tmr_under && !tmr_pending |=> underflow_irq)
    else $error("missing underflow interrupt");
  reload_primary_a: assert property (@(posedge clock) disable iff (srst)
    is_timer && tmr_under && !tmr_pending && !reg_write.wr_primary &&
      !(ctrl_write && forced_stop_bit) |=> reg_read.primary_reload_reg == $past(pri_reload))
    else $error("timer did not reload primary");
  idle_frozen_a: assert property (@(posedge clock) disable iff (srst)
    !running && reg_write.wr_primary && !(ctrl_write && forced_stop_bit)
      |=> reg_read.primary_reload_reg == $past(reg_write.data))
    else $error("stopped write missed counter");
  no_secondary_a: assert property (@(posedge clock) disable iff (srst)
    is_timer |-> !in_secondary)
    else $error("secondary used in timer mode");

  // ----------------------------------------------------------------
  // Checks on reload and write paths
  // ----------------------------------------------------------------
  prescale_reload_a: assert property (@(posedge clock) disable iff (srst)
    pre_under && !pre_pending && !(ctrl_write && forced_stop_bit)
      |=> reg_read.prescaler_reg == $past(pre_reload))
    else $error("prescaler did not reload");
  stopped_hold_a: assert property (@(posedge clock) disable iff (srst)
    !running && !reg_write.wr_primary && !(ctrl_write && forced_stop_bit)
      |=> $stable(reg_read.primary_reload_reg))
    else $error("timer moved while stopped");
  oneshot_gate_a: assert property (@(posedge clock) disable iff (srst)
    !is_oneshot && !oneshot_status_flag |=> !oneshot_status_flag)
    else $error("one-shot status set outside one-shot modes");
  reload_only_a: assert property (@(posedge clock) disable iff (srst)
    running && mode_cfg.write_target_sel && reg_write.wr_primary && !tmr_pending
      |=> !tmr_pending)
    else $error("reload-only write reached the counter");
  secondary_lock_a: assert property (@(posedge clock) disable iff (srst)
    is_timer && reg_write.wr_secondary && !(ctrl_write && forced_stop_bit)
      |=> reg_read.secondary_reload_reg == $past(sec_reload))
    else $error("secondary written in timer mode");
  alternate_load_a: assert property (@(posedge clock) disable iff (srst)
    !is_timer && tmr_under && !tmr_pending && !in_secondary &&
      !(ctrl_write && forced_stop_bit) |=> reg_read.primary_reload_reg == $past(sec_reload))
    else $error("secondary value not loaded after primary");
  cov_oneshot_c: cover property (@(posedge clock) disable iff (srst) $rose(oneshot_status_flag));
  cov_irq_c: cover property (@(posedge clock) disable iff (srst) underflow_irq);
  cov_alt_c: cover property (@(posedge clock) disable iff (srst) $rose(in_secondary));
  cov_pend_c: cover property (@(posedge clock) disable iff (srst) tmr_pending ##[1:50] !tmr_pending);

endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking testbench for the prescaled timer b
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Stimulus, observed outputs and bookkeeping
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ctrl_write = 1'b0;
  logic count_start_bit = 1'b0;
  logic forced_stop_bit = 1'b0;
  timer_b_pkg::mode_cfg_t mode_cfg = '0;
  logic oneshot_trigger = 1'b0;
  timer_b_pkg::reg_write_t reg_write = '0;
  logic companion_underflow = 1'b0;
  logic comp_en = 1'b0;
  int comp_cnt = 0;
  timer_b_pkg::reg_read_t reg_read;
  logic start_state;
  logic count_status_flag;
  logic oneshot_status_flag;
  logic underflow_irq;
  int err_count = 0;
  int n_compared = 0;
  int per;
  int k;
  logic [7:0] prev;
  logic [1:0] src_tab [4] = '{timer_b_pkg::SRC_F1, timer_b_pkg::SRC_F2,
                              timer_b_pkg::SRC_F8, timer_b_pkg::SRC_COMPANION};
  int div_tab [4] = '{1, 2, 8, 3};

  prescaled_timer_b i_dut (
    .clock(clock),
    .srst(srst),
    .ctrl_write(ctrl_write),
    .count_start_bit(count_start_bit),
    .forced_stop_bit(forced_stop_bit),
    .mode_cfg(mode_cfg),
    .oneshot_trigger(oneshot_trigger),
    .reg_write(reg_write),
    .companion_underflow(companion_underflow),
    .reg_read(reg_read),
    .start_state(start_state),
    .count_status_flag(count_status_flag),
    .oneshot_status_flag(oneshot_status_flag),
    .underflow_irq(underflow_irq)
  );

  always #50 clock = ~clock;

  // Companion pulses every third cycle, so its period differs from every divider
  always begin
    @(posedge clock);
    #1;
    comp_cnt = (comp_cnt == 2) ? 0 : comp_cnt + 1;
    companion_underflow = comp_en && (comp_cnt == 0);
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic note(input logic bad, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (bad) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    note(got !== exp, 32'(got), 32'(exp));
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    note(got !== exp, 32'(got), 32'(exp));
  endtask

  task automatic cmp_int(input int got, input int exp);
    note(got != exp, got, exp);
  endtask

  // Strobes drop for a cycle between writes so no signal is assigned twice at once
  task automatic wr(input int which, input logic [7:0] d);
    reg_write = '{which == 0, which == 1, which == 2, d};
    step(1);
    reg_write = '0;
    step(1);
  endtask

  task automatic ctrl(input logic start, input logic stop);
    ctrl_write = 1'b1;
    count_start_bit = start;
    forced_stop_bit = stop;
    step(1);
    ctrl_write = 1'b0;
    step(1);
  endtask

  task automatic wait_status(input logic v);
    int i;
    for (i = 0; i < 40 && count_status_flag !== v; i++) step(1);
    cmp_bit(count_status_flag, v);
    if (count_status_flag !== v) conclude();
  endtask

  task automatic trigger();
    oneshot_trigger = 1'b1;
    step(1);
    oneshot_trigger = 1'b0;
    step(1);
  endtask

  // Cycles between two interrupt pulses
  task automatic period(output int p);
    int i;
    for (i = 0; i < 3000 && underflow_irq !== 1'b1; i++) step(1);
    if (underflow_irq !== 1'b1) begin
      cmp_bit(underflow_irq, 1'b1);
      conclude();
    end
    step(1);
    cmp_bit(underflow_irq, 1'b0);
    for (p = 1; p < 3000 && underflow_irq !== 1'b1; p++) step(1);
    if (underflow_irq !== 1'b1) begin
      cmp_bit(underflow_irq, 1'b1);
      conclude();
    end
  endtask

  // Mode is only touched once the status flag has dropped
  task automatic run(input logic [1:0] md, input logic [1:0] src, input logic tw,
                     input logic [7:0] pre, input logic [7:0] sec, input logic [7:0] pri);
    ctrl(1'b0, 1'b0);
    wait_status(1'b0);
    mode_cfg = '{md, src, 1'b0, tw};
    step(1);
    wr(0, pre);
    wr(1, sec);
    wr(2, pri);
    ctrl(1'b1, 1'b0);
    wait_status(1'b1);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    step(6);
    srst = 1'b0;
    step(1);
    cmp_byte(reg_read.prescaler_reg, 8'hFF);
    cmp_byte(reg_read.primary_reload_reg, 8'hFF);
    cmp_byte(reg_read.secondary_reload_reg, 8'hFF);
    cmp_bit(start_state, 1'b0);
    cmp_bit(count_status_flag, 1'b0);
    cmp_bit(oneshot_status_flag, 1'b0);
    $display("test reset done");

    wr(0, 8'h12);
    wr(2, 8'h34);
    wr(1, 8'h56);
    cmp_byte(reg_read.prescaler_reg, 8'h12);
    cmp_byte(reg_read.primary_reload_reg, 8'h34);
    cmp_byte(reg_read.secondary_reload_reg, 8'hFF);
    ctrl(1'b1, 1'b0);
    trigger();
    cmp_bit(oneshot_status_flag, 1'b0);
    cmp_bit(start_state, 1'b1);
    $display("test stopped writes done");

    for (k = 0; k < 4; k++) begin
      comp_en = (src_tab[k] == timer_b_pkg::SRC_COMPANION);
      run(timer_b_pkg::MODE_TIMER, src_tab[k], 1'b0, 8'h01, 8'h00, 8'h02);
      period(per);
      cmp_int(per, 6 * div_tab[k]);
    end
    comp_en = 1'b0;
    $display("test sources done");

    run(timer_b_pkg::MODE_TIMER, timer_b_pkg::SRC_F1, 1'b0, 8'h00, 8'h00, 8'h03);
    prev = 8'h03;
    cmp_byte(reg_read.primary_reload_reg, prev);
    for (k = 0; k < 10; k++) begin
      step(1);
      prev = (prev == 8'h00) ? 8'h03 : prev - 8'h01;
      cmp_byte(reg_read.primary_reload_reg, prev);
    end
    ctrl(1'b0, 1'b0);
    wait_status(1'b0);
    prev = reg_read.primary_reload_reg;
    step(10);
    cmp_byte(reg_read.primary_reload_reg, prev);
    // A cut source must keep the block from ever reaching the counting state
    mode_cfg.source_cut_bit = 1'b1;
    step(1);
    ctrl(1'b1, 1'b0);
    step(10);
    cmp_bit(count_status_flag, 1'b0);
    cmp_byte(reg_read.primary_reload_reg, prev);
    ctrl(1'b0, 1'b0);
    wait_status(1'b0);
    mode_cfg.source_cut_bit = 1'b0;
    $display("test count and stop done");

    run(timer_b_pkg::MODE_TIMER, timer_b_pkg::SRC_F1, 1'b1, 8'h00, 8'h00, 8'hC8);
    wr(2, 8'h03);
    step(2);
    cmp_bit(reg_read.primary_reload_reg > 8'h64, 1'b1);
    period(per);
    cmp_int(per, 4);
    run(timer_b_pkg::MODE_TIMER, timer_b_pkg::SRC_F1, 1'b0, 8'h00, 8'h00, 8'hC8);
    wr(2, 8'h03);
    step(3);
    cmp_bit(reg_read.primary_reload_reg <= 8'h03, 1'b1);
    $display("test running writes done");

    run(timer_b_pkg::MODE_WAVE, timer_b_pkg::SRC_F1, 1'b1, 8'h00, 8'h01, 8'h03);
    cmp_byte(reg_read.secondary_reload_reg, 8'h01);
    period(per);
    cmp_int(per, 6);
    $display("test alternating reload done");

    ctrl(1'b0, 1'b0);
    wait_status(1'b0);
    mode_cfg = '{timer_b_pkg::MODE_ONESHOT, timer_b_pkg::SRC_F1, 1'b0, 1'b1};
    step(1);
    ctrl(1'b1, 1'b0);
    cmp_bit(count_status_flag, 1'b0);
    trigger();
    cmp_bit(oneshot_status_flag, 1'b1);
    wait_status(1'b1);
    ctrl(1'b1, 1'b1);
    cmp_byte(reg_read.prescaler_reg, 8'hFF);
    cmp_byte(reg_read.primary_reload_reg, 8'hFF);
    cmp_byte(reg_read.secondary_reload_reg, 8'hFF);
    cmp_bit(start_state, 1'b0);
    cmp_bit(count_status_flag, 1'b0);
    cmp_bit(oneshot_status_flag, 1'b0);
    $display("test forced stop done");
    conclude();
  end
endmodule
`default_nettype wire
